// ==== hw/tai_pkg.sv ====
// Constants, register map and field layout of the temperature alarm block.
// Assumes a 125 MHz MCLK and a 32-bit Avalon-MM slave port with byte addresses.
// Overview of operation
// - At each conversion start, sample the open-diode comparator; a fault sets status bit 2.
// - With the pin in alarm mode, a new open-diode fault pulls the alarm low.
// - Alarm is maskable by configuration; primary trip output has no mask at all.
// - Alarm asserts when a channel is above high limit or at/below low limit.
// - After alert response, alarm releases only once conditions and status are clear.
// - Primary trip goes low when either channel exceeds its own trip limit.
// - Trip releases by itself when temperature falls to limit minus hysteresis.
// - Hysteresis resets to ten degrees and accepts any later written value.
// - Hysteresis is an eight-bit unsigned count, one degree per bit.
// - Shared pin works either as maskable alarm or as second trip output.
// - Second trip goes low above high limits, unmasked, released through hysteresis.
// - Local and remote results each drive both trip outputs against own limits.
// - Signed offset is added to each remote result before storing and comparing.
// - Host services alarm via alert response; an alarming device answers its address.
// - Alarm pin is open drain, only pulls low, for a shared wired line.

package tai_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_HYST = 8'h0C;
    localparam logic [7:0] OFS_OFFSET = 8'h10;
    localparam logic [7:0] OFS_LOC_HIGH = 8'h14;
    localparam logic [7:0] OFS_LOC_LOW = 8'h18;
    localparam logic [7:0] OFS_LOC_TRIP = 8'h1C;
    localparam logic [7:0] OFS_REM_HIGH = 8'h20;
    localparam logic [7:0] OFS_REM_LOW = 8'h24;
    localparam logic [7:0] OFS_REM_TRIP = 8'h28;
    localparam logic [7:0] OFS_LOC_TEMP = 8'h2C;
    localparam logic [7:0] OFS_REM_TEMP = 8'h30;

    // Configuration fields
    localparam int CFG_ALARM_MASK = 0;
    localparam int CFG_PIN_MODE = 1;
    localparam int CFG_PIN_LEVEL = 7;

    // Status / interrupt mask fields
    localparam int ST_LOC_TRIP = 0;
    localparam int ST_REM_TRIP = 1;
    localparam int ST_OPEN = 2;
    localparam int ST_REM_LOW = 3;
    localparam int ST_REM_HIGH = 4;
    localparam int ST_LOC_LOW = 5;
    localparam int ST_LOC_HIGH = 6;
    localparam logic [7:0] ST_ALARM_GROUP = 8'h7C;

    // Reset values
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_HYST = 8'h0A;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_HIGH = 8'h55;
    localparam logic [7:0] RST_LOW = 8'h00;
    localparam logic [7:0] RST_TRIP = 8'h6C;
    localparam logic [7:0] RST_TEMP = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Own bus address, value is arbitrary
    localparam logic [6:0] OWN_ADDR = 7'h2A;

endpackage : tai_pkg

// ==== hw/tai_trip_hyst.sv ====
// One trip comparator with hysteresis for a single channel and limit.
// Assumes upd pulses in the cycle a new result is presented on temp.
`timescale 1ns/1ps

module tai_trip_hyst (
    input wire logic clk,
    input wire logic rst,
    input wire logic upd,
    input wire logic [7:0] temp,
    input wire logic [7:0] limit,
    input wire logic [7:0] hyst,
    output logic active
);

    logic [8:0] diff;
    logic [7:0] floor_val;

    // Release threshold, saturates at zero for large hysteresis
    assign diff = {1'b0, limit} - {1'b0, hyst};
    assign floor_val = diff[8] ? 8'h00 : diff[7:0];

    // Set above limit, clear at or below floor, else hold
    always_ff @(posedge clk) begin
        if (rst) begin
            active <= 1'b0;
        end else if (upd) begin
            if (temp > limit) begin
                active <= 1'b1;
            end else if (temp <= floor_val) begin
                active <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_trip_sets: assert property (upd && temp > limit |=> active)
        else $error("trip not set above limit");
    a_trip_release: assert property (upd && temp <= limit && temp <= floor_val |=> !active)
        else $error("trip not released at floor");
    a_trip_holds: assert property (active && upd && temp > floor_val |=> active)
        else $error("trip released inside hysteresis band");
    a_trip_quiet: assert property (!upd |=> $stable(active))
        else $error("trip changed without a new result");

endmodule : tai_trip_hyst

// ==== hw/tai_alarm_top.sv ====
// Alarm and trip logic of a two-channel temperature monitor with Avalon-MM registers.
// Assumes conversion results and alert response strobes come from logic on MCLK;
// the open-diode comparator and the shared pin level are asynchronous.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

module tai_alarm_top (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic CONV_START,
    input wire logic OPEN_COMPARATOR,
    input wire logic LOCAL_VALID,
    input wire logic [7:0] LOCAL_RESULT,
    input wire logic REMOTE_VALID,
    input wire logic [7:0] REMOTE_RESULT,
    input wire logic ARA_READ,
    output logic ARA_RESPOND,
    output logic [7:0] ARA_ADDR_BYTE,
    output logic FAILSAFE_TRIP_N,
    input wire logic SHARED_ALARM_TRIP_PIN_I,
    output logic SHARED_ALARM_TRIP_PIN_O,
    output logic SHARED_ALARM_TRIP_PIN_OE,
    output logic IRQ
);

    // Register state
    logic [7:0] cfg;
    logic [7:0] status;
    logic [7:0] irq_mask;
    logic [7:0] hyst;
    logic [7:0] offset;
    logic [7:0] loc_high;
    logic [7:0] loc_low;
    logic [7:0] loc_trip;
    logic [7:0] rem_high;
    logic [7:0] rem_low;
    logic [7:0] rem_trip;
    logic [7:0] loc_temp;
    logic [7:0] rem_temp;

    // Bus handshake
    logic ack;
    logic wr_go;
    logic wr_lane;

    // Synchronisers
    logic open_meta;
    logic open_sync;
    logic pin_meta;
    logic pin_sync;

    // Conditions and outputs
    logic open_live;
    logic loc_cond;
    logic rem_cond;
    logic alarm_active;
    logic alarm_set;
    logic alarm_clear_ok;
    logic alarm_mode;
    logic alarm_masked;
    logic trip_loc;
    logic trip_rem;
    logic sec_loc;
    logic sec_rem;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] next_status;
    logic [7:0] rd_mux;
    logic [9:0] rem_sum;
    logic [7:0] rem_adj;

    // Configuration decode
    assign alarm_masked = cfg[tai_pkg::CFG_ALARM_MASK];
    assign alarm_mode = ~cfg[tai_pkg::CFG_PIN_MODE];

    // Avalon-MM: one wait cycle, then the answer
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
    assign wr_go = AVS_WRITE & ack;
    assign wr_lane = wr_go & AVS_BYTEENABLE[0];

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ack <= 1'b0;
        end else begin
            ack <= (AVS_READ | AVS_WRITE) & ~ack;
        end
    end

    // Read multiplexer, unmapped addresses read zero
    always_comb begin
        rd_mux = tai_pkg::RST_ZERO;
        unique case (AVS_ADDRESS)
            tai_pkg::OFS_CONFIG: begin
                rd_mux = cfg;
                rd_mux[tai_pkg::CFG_PIN_LEVEL] = pin_sync;
            end
            tai_pkg::OFS_STATUS: rd_mux = status;
            tai_pkg::OFS_IRQ_MASK: rd_mux = irq_mask;
            tai_pkg::OFS_HYST: rd_mux = hyst;
            tai_pkg::OFS_OFFSET: rd_mux = offset;
            tai_pkg::OFS_LOC_HIGH: rd_mux = loc_high;
            tai_pkg::OFS_LOC_LOW: rd_mux = loc_low;
            tai_pkg::OFS_LOC_TRIP: rd_mux = loc_trip;
            tai_pkg::OFS_REM_HIGH: rd_mux = rem_high;
            tai_pkg::OFS_REM_LOW: rd_mux = rem_low;
            tai_pkg::OFS_REM_TRIP: rd_mux = rem_trip;
            tai_pkg::OFS_LOC_TEMP: rd_mux = loc_temp;
            tai_pkg::OFS_REM_TEMP: rd_mux = rem_temp;
            default: rd_mux = tai_pkg::RST_ZERO;
        endcase
    end

    // Read data captured while waitrequest is high
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && !ack) begin
            AVS_READDATA <= {24'h00_0000, rd_mux};
        end
    end

    // Writable control registers
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            cfg <= tai_pkg::RST_CONFIG;
            irq_mask <= tai_pkg::RST_ZERO;
            hyst <= tai_pkg::RST_HYST;
            offset <= tai_pkg::RST_OFFSET;
        end else if (wr_lane) begin
            unique case (AVS_ADDRESS)
                tai_pkg::OFS_CONFIG: cfg <= {6'h00, AVS_WRITEDATA[1:0]};
                tai_pkg::OFS_IRQ_MASK: irq_mask <= AVS_WRITEDATA[7:0];
                tai_pkg::OFS_HYST: hyst <= AVS_WRITEDATA[7:0];
                tai_pkg::OFS_OFFSET: offset <= AVS_WRITEDATA[7:0];
                default: ;
            endcase
        end
    end

    // Limit registers
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            loc_high <= tai_pkg::RST_HIGH;
            loc_low <= tai_pkg::RST_LOW;
            loc_trip <= tai_pkg::RST_TRIP;
            rem_high <= tai_pkg::RST_HIGH;
            rem_low <= tai_pkg::RST_LOW;
            rem_trip <= tai_pkg::RST_TRIP;
        end else if (wr_lane) begin
            unique case (AVS_ADDRESS)
                tai_pkg::OFS_LOC_HIGH: loc_high <= AVS_WRITEDATA[7:0];
                tai_pkg::OFS_LOC_LOW: loc_low <= AVS_WRITEDATA[7:0];
                tai_pkg::OFS_LOC_TRIP: loc_trip <= AVS_WRITEDATA[7:0];
                tai_pkg::OFS_REM_HIGH: rem_high <= AVS_WRITEDATA[7:0];
                tai_pkg::OFS_REM_LOW: rem_low <= AVS_WRITEDATA[7:0];
                tai_pkg::OFS_REM_TRIP: rem_trip <= AVS_WRITEDATA[7:0];
                default: ;
            endcase
        end
    end

    // Two-flop synchronisers for asynchronous inputs
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            open_meta <= 1'b0;
            open_sync <= 1'b0;
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            open_meta <= OPEN_COMPARATOR;
            open_sync <= open_meta;
            pin_meta <= SHARED_ALARM_TRIP_PIN_I;
            pin_sync <= pin_meta;
        end
    end

    // Remote result plus signed offset, clamped to the 8-bit range
    assign rem_sum = {2'b00, REMOTE_RESULT} + {{2{offset[7]}}, offset};
    assign rem_adj = rem_sum[9] ? 8'h00 : (rem_sum[8] ? 8'hFF : rem_sum[7:0]);

    // Stored conversion results
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            loc_temp <= tai_pkg::RST_TEMP;
            rem_temp <= tai_pkg::RST_TEMP;
        end else begin
            if (LOCAL_VALID) begin
                loc_temp <= LOCAL_RESULT;
            end
            if (REMOTE_VALID) begin
                rem_temp <= rem_adj;
            end
        end
    end

    // Event vector, evaluated on the result being stored
    always_comb begin
        set_vec = tai_pkg::RST_ZERO;
        set_vec[tai_pkg::ST_LOC_TRIP] = LOCAL_VALID && (LOCAL_RESULT > loc_trip);
        set_vec[tai_pkg::ST_REM_TRIP] = REMOTE_VALID && (rem_adj > rem_trip);
        set_vec[tai_pkg::ST_OPEN] = CONV_START && open_sync;
        set_vec[tai_pkg::ST_LOC_HIGH] = LOCAL_VALID && (LOCAL_RESULT > loc_high);
        set_vec[tai_pkg::ST_LOC_LOW] = LOCAL_VALID && (LOCAL_RESULT <= loc_low);
        set_vec[tai_pkg::ST_REM_HIGH] = REMOTE_VALID && (rem_adj > rem_high);
        set_vec[tai_pkg::ST_REM_LOW] = REMOTE_VALID && (rem_adj <= rem_low);
    end

    // Write-one-to-clear, a new event wins over the clear
    assign clr_vec = (wr_lane && AVS_ADDRESS == tai_pkg::OFS_STATUS) ? AVS_WRITEDATA[7:0] : 8'h00;
    assign next_status = (status & ~clr_vec) | set_vec;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            status <= tai_pkg::RST_ZERO;
        end else begin
            status <= next_status;
        end
    end

    // Level interrupt from unmasked sticky bits
    assign IRQ = |(status & irq_mask);

    // Live conditions per channel, held until the next result
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            open_live <= 1'b0;
            loc_cond <= 1'b0;
            rem_cond <= 1'b0;
        end else begin
            if (CONV_START) begin
                open_live <= open_sync;
            end
            if (LOCAL_VALID) begin
                loc_cond <= set_vec[tai_pkg::ST_LOC_HIGH] | set_vec[tai_pkg::ST_LOC_LOW];
            end
            if (REMOTE_VALID) begin
                rem_cond <= set_vec[tai_pkg::ST_REM_HIGH] | set_vec[tai_pkg::ST_REM_LOW];
            end
        end
    end

    // Alarm latch: set by unmasked alarm events, cleared by a served alert response
    assign alarm_set = |(set_vec & tai_pkg::ST_ALARM_GROUP) && alarm_mode && !alarm_masked;
    assign alarm_clear_ok = !open_live && !loc_cond && !rem_cond
        && ((status & tai_pkg::ST_ALARM_GROUP) == 8'h00);

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            alarm_active <= 1'b0;
        end else if (alarm_set) begin
            alarm_active <= 1'b1;
        end else if (ARA_READ && alarm_clear_ok) begin
            alarm_active <= 1'b0;
        end
    end

    // Alert response answer: asserted device gives its address with LSB set
    assign ARA_RESPOND = alarm_active && alarm_mode;
    assign ARA_ADDR_BYTE = {tai_pkg::OWN_ADDR, 1'b1};

    // Trip comparators, each channel against its own limits
    tai_trip_hyst u_trip_loc (
        .clk(MCLK),
        .rst(SRST),
        .upd(LOCAL_VALID),
        .temp(LOCAL_RESULT),
        .limit(loc_trip),
        .hyst(hyst),
        .active(trip_loc)
    );

    tai_trip_hyst u_trip_rem (
        .clk(MCLK),
        .rst(SRST),
        .upd(REMOTE_VALID),
        .temp(rem_adj),
        .limit(rem_trip),
        .hyst(hyst),
        .active(trip_rem)
    );

    tai_trip_hyst u_sec_loc (
        .clk(MCLK),
        .rst(SRST),
        .upd(LOCAL_VALID),
        .temp(LOCAL_RESULT),
        .limit(loc_high),
        .hyst(hyst),
        .active(sec_loc)
    );

    tai_trip_hyst u_sec_rem (
        .clk(MCLK),
        .rst(SRST),
        .upd(REMOTE_VALID),
        .temp(rem_adj),
        .limit(rem_high),
        .hyst(hyst),
        .active(sec_rem)
    );

    // Registered pin drivers; shared pin only ever pulls low
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            FAILSAFE_TRIP_N <= 1'b1;
            SHARED_ALARM_TRIP_PIN_OE <= 1'b0;
        end else begin
            FAILSAFE_TRIP_N <= ~(trip_loc | trip_rem);
            SHARED_ALARM_TRIP_PIN_OE <= alarm_mode ? alarm_active : (sec_loc | sec_rem);
        end
    end
    assign SHARED_ALARM_TRIP_PIN_O = 1'b0;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    a_open_flag_set: assert property (CONV_START && open_sync |=> status[tai_pkg::ST_OPEN])
        else $error("open flag not set on fault");
    a_open_drives_alarm: assert property (
        CONV_START && open_sync && alarm_mode && !alarm_masked |=> ##1 SHARED_ALARM_TRIP_PIN_OE)
        else $error("open fault did not pull alarm low");
    a_mask_blocks_alarm: assert property (
        !alarm_active && alarm_masked && alarm_mode |=> !alarm_active)
        else $error("masked alarm asserted");
    a_trip_ignores_mask: assert property (
        LOCAL_VALID && LOCAL_RESULT > loc_trip |=> ##1 !FAILSAFE_TRIP_N)
        else $error("primary trip missed");
    a_high_alarm: assert property (
        REMOTE_VALID && rem_adj > rem_high && alarm_mode && !alarm_masked
        |=> alarm_active ##1 SHARED_ALARM_TRIP_PIN_OE)
        else $error("high limit did not raise alarm");
    a_alarm_needs_ara: assert property (alarm_active && !ARA_READ |=> alarm_active)
        else $error("alarm released without alert response");
    a_alarm_release: assert property (
        ARA_READ && alarm_clear_ok && !alarm_set |=> !alarm_active ##1 !SHARED_ALARM_TRIP_PIN_OE
        || !alarm_mode)
        else $error("alarm not released after service");
    a_hyst_reset: assert property (
        @(posedge MCLK) disable iff (1'b0) SRST |=> hyst == tai_pkg::RST_HYST)
        else $error("hysteresis reset value wrong");
    a_offset_sum: assert property (
        REMOTE_VALID && !rem_sum[9] && !rem_sum[8]
        |=> rem_temp == $past(REMOTE_RESULT) + $past(offset))
        else $error("remote offset not applied");
    a_second_trip: assert property (
        REMOTE_VALID && rem_adj > rem_high && !alarm_mode |-> ##2 SHARED_ALARM_TRIP_PIN_OE)
        else $error("second trip missed");
    a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && !ack |=> !AVS_WAITREQUEST)
        else $error("bus answer late");

    c_open_alarm: cover property (CONV_START && open_sync ##[1:20] SHARED_ALARM_TRIP_PIN_OE);
    c_trip_cycle: cover property ($fell(FAILSAFE_TRIP_N) ##[1:200] $rose(FAILSAFE_TRIP_N));
    c_ara_release: cover property (alarm_active ##1 !alarm_active);
    c_second_trip: cover property (!alarm_mode && SHARED_ALARM_TRIP_PIN_OE);

endmodule : tai_alarm_top

// ==== sim/tai_host_model.sv ====
// Behavioural SMBus host with the pull-up of the shared alarm line.
// Assumes the bench pulses service on clk to ask for an alert response read.
`timescale 1ns/1ps

module tai_host_model (
    input wire logic clk,
    input wire logic service,
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic ara_respond,
    input wire logic [7:0] ara_addr_byte,
    output logic pin_i,
    output logic ara_read,
    output logic [7:0] served
);
    // Pull-up resolves the open-drain line
    assign pin_i = pin_oe ? pin_o : 1'b1;

    initial begin
        ara_read = 1'b0;
        served = 8'h00;
    end

    // Alert response read only while the shared line is low
    always @(posedge clk) begin
        ara_read <= service && !pin_i && ara_respond;
        if (service && !pin_i && ara_respond) begin
            served <= ara_addr_byte;
        end
    end
endmodule : tai_host_model

// ==== sim/tai_alarm_top_test.sv ====
// Self-checking bench for the temperature alarm block.
// Assumes the host model in its own file and the block's package.
`timescale 1ns/1ps

module tai_alarm_top_test;
    logic MCLK = 1'b0, SRST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [7:0] AVS_ADDRESS = 8'h00, LOCAL_RESULT = 8'h00, REMOTE_RESULT = 8'h00;
    logic [31:0] AVS_WRITEDATA = 32'h00000000, AVS_READDATA, q;
    logic CONV_START = 1'b0, OPEN_COMPARATOR = 1'b0, LOCAL_VALID = 1'b0;
    logic REMOTE_VALID = 1'b0, service = 1'b0, AVS_WAITREQUEST, ARA_READ, ARA_RESPOND;
    logic FAILSAFE_TRIP_N, PIN_I, PIN_O, PIN_OE, IRQ;
    logic [7:0] ARA_ADDR_BYTE, served;
    int miscompares = 0, samples_checked = 0;

    tai_alarm_top DUT (.MCLK(MCLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .CONV_START(CONV_START),
        .OPEN_COMPARATOR(OPEN_COMPARATOR), .LOCAL_VALID(LOCAL_VALID),
        .LOCAL_RESULT(LOCAL_RESULT), .REMOTE_VALID(REMOTE_VALID),
        .REMOTE_RESULT(REMOTE_RESULT), .ARA_READ(ARA_READ), .ARA_RESPOND(ARA_RESPOND),
        .ARA_ADDR_BYTE(ARA_ADDR_BYTE), .FAILSAFE_TRIP_N(FAILSAFE_TRIP_N),
        .SHARED_ALARM_TRIP_PIN_I(PIN_I), .SHARED_ALARM_TRIP_PIN_O(PIN_O),
        .SHARED_ALARM_TRIP_PIN_OE(PIN_OE), .IRQ(IRQ));

    tai_host_model host (.clk(MCLK), .service(service), .pin_o(PIN_O), .pin_oe(PIN_OE),
        .ara_respond(ARA_RESPOND), .ara_addr_byte(ARA_ADDR_BYTE), .pin_i(PIN_I),
        .ara_read(ARA_READ), .served(served));

    // 125 MHz clock
    initial begin
        forever #4 MCLK = ~MCLK;
    end

    task test_done();
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    // One Avalon-MM cycle, held until waitrequest is sampled low at a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h000000, d};
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do begin
            @(posedge MCLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
        if (AVS_WAITREQUEST !== 1'b0) begin
            miscompares++;
            $display("wrong value at %0t: bus wait ran out", $time);
            test_done();
        end
        // Read data taken at the completing edge, then the request drops
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(negedge MCLK);
    endtask : bus

    // Conversion result pulse, then settle past the output register
    task conv(input logic r, input logic [7:0] v);
        @(posedge MCLK);
        LOCAL_VALID <= !r;
        REMOTE_VALID <= r;
        LOCAL_RESULT <= v;
        REMOTE_RESULT <= v;
        @(posedge MCLK);
        LOCAL_VALID <= 1'b0;
        REMOTE_VALID <= 1'b0;
        repeat (1) @(posedge MCLK);
        @(negedge MCLK);
    endtask : conv

    // Conversion start with the comparator settled through its synchroniser
    task cs(input logic c);
        @(posedge MCLK);
        OPEN_COMPARATOR <= c;
        repeat (4) @(posedge MCLK);
        CONV_START <= 1'b1;
        @(posedge MCLK);
        CONV_START <= 1'b0;
        @(posedge MCLK);
        @(negedge MCLK);
    endtask : cs

    task svc();
        @(posedge MCLK);
        service <= 1'b1;
        @(posedge MCLK);
        service <= 1'b0;
        repeat (2) @(posedge MCLK);
        @(negedge MCLK);
    endtask : svc

    // Both channels in limits, status cleared, alarm serviced
    task quiet();
        conv(1'b0, 8'h20);
        conv(1'b1, 8'h20);
        cs(1'b0);
        bus(1'b1, tai_pkg::OFS_STATUS, 8'h7F);
        svc();
    endtask : quiet

    task t_reset();
        bus(1'b0, tai_pkg::OFS_HYST, 8'h00);
        chk(q, 32'h0000000A, "hyst reset");
        chk(32'(FAILSAFE_TRIP_N), 32'h1, "trip idle");
        chk(32'(PIN_OE), 32'h0, "pin idle");
        bus(1'b0, 8'hFC, 8'h00);
        chk(q, 32'h00000000, "unmapped read");
        bus(1'b0, tai_pkg::OFS_LOC_TRIP, 8'h00);
        chk(q, 32'(tai_pkg::RST_TRIP), "trip limit above high");
        bus(1'b1, tai_pkg::OFS_HYST, 8'hFF);
        bus(1'b0, tai_pkg::OFS_HYST, 8'h00);
        chk(q, 32'h000000FF, "hyst max");
        bus(1'b1, tai_pkg::OFS_HYST, 8'h03);
        bus(1'b0, tai_pkg::OFS_HYST, 8'h00);
        chk(q, 32'h00000003, "hyst three");
        $display("reset and hysteresis test done");
    endtask : t_reset

    task t_trip();
        quiet();
        conv(1'b0, 8'h6C);
        chk(32'(FAILSAFE_TRIP_N), 32'h1, "at limit");
        conv(1'b0, 8'h6D);
        chk(32'(FAILSAFE_TRIP_N), 32'h0, "local over");
        conv(1'b0, 8'h6A);
        chk(32'(FAILSAFE_TRIP_N), 32'h0, "in band");
        conv(1'b0, 8'h69);
        chk(32'(FAILSAFE_TRIP_N), 32'h1, "released");
        conv(1'b1, 8'h6D);
        chk(32'(FAILSAFE_TRIP_N), 32'h0, "remote over");
        conv(1'b1, 8'h69);
        chk(32'(FAILSAFE_TRIP_N), 32'h1, "remote released");
        $display("trip test done");
    endtask : t_trip

    task t_offset();
        bus(1'b1, tai_pkg::OFS_OFFSET, 8'h03 + 8'h02);
        conv(1'b1, 8'h10);
        bus(1'b0, tai_pkg::OFS_REM_TEMP, 8'h00);
        chk(q, 32'h00000015, "plus offset");
        conv(1'b1, 8'h68);
        chk(32'(FAILSAFE_TRIP_N), 32'h0, "offset trip");
        bus(1'b1, tai_pkg::OFS_OFFSET, 8'hFB);
        conv(1'b1, 8'h10);
        bus(1'b0, tai_pkg::OFS_REM_TEMP, 8'h00);
        chk(q, 32'h0000000B, "minus offset");
        bus(1'b1, tai_pkg::OFS_OFFSET, 8'h00);
        $display("offset test done");
    endtask : t_offset

    task t_alarm();
        quiet();
        conv(1'b0, 8'h55);
        chk(32'(PIN_OE), 32'h0, "at high");
        conv(1'b0, 8'h56);
        chk(32'(PIN_OE), 32'h1, "above high");
        chk(32'(IRQ), 32'h0, "irq masked");
        bus(1'b1, tai_pkg::OFS_IRQ_MASK, 8'h40);
        chk(32'(IRQ), 32'h1, "irq raised");
        svc();
        chk(32'(PIN_OE), 32'h1, "live condition");
        conv(1'b0, 8'h20);
        svc();
        chk(32'(PIN_OE), 32'h1, "status set");
        bus(1'b1, tai_pkg::OFS_STATUS, 8'h7F);
        chk(32'(IRQ), 32'h0, "irq cleared");
        svc();
        chk(32'(PIN_OE), 32'h0, "alarm released");
        chk(32'(served), {24'h000000, tai_pkg::OWN_ADDR, 1'b1}, "ara answer");
        bus(1'b1, tai_pkg::OFS_IRQ_MASK, 8'h00);
        bus(1'b1, tai_pkg::OFS_LOC_LOW, 8'h10);
        conv(1'b0, 8'h11);
        chk(32'(PIN_OE), 32'h0, "above low");
        conv(1'b0, 8'h10);
        chk(32'(PIN_OE), 32'h1, "at low");
        bus(1'b1, tai_pkg::OFS_LOC_LOW, 8'h00);
        $display("alarm test done");
    endtask : t_alarm

    task t_mask();
        quiet();
        bus(1'b1, tai_pkg::OFS_CONFIG, 8'h01);
        conv(1'b0, 8'h6D);
        chk(32'(PIN_OE), 32'h0, "alarm masked");
        chk(32'(FAILSAFE_TRIP_N), 32'h0, "trip unmasked");
        cs(1'b1);
        chk(32'(PIN_OE), 32'h0, "open masked");
        bus(1'b1, tai_pkg::OFS_CONFIG, 8'h00);
        quiet();
        cs(1'b1);
        bus(1'b0, tai_pkg::OFS_STATUS, 8'h00);
        chk(q & 32'h00000004, 32'h00000004, "open flag");
        chk(32'(PIN_OE), 32'h1, "open alarm");
        bus(1'b1, tai_pkg::OFS_STATUS, 8'h7F);
        svc();
        chk(32'(PIN_OE), 32'h1, "open still live");
        quiet();
        chk(32'(PIN_OE), 32'h0, "open released");
        $display("mask and open test done");
    endtask : t_mask

    task t_second();
        bus(1'b1, tai_pkg::OFS_CONFIG, 8'h03);
        conv(1'b0, 8'h56);
        chk(32'(PIN_OE), 32'h1, "second trip");
        chk(32'(PIN_O), 32'h0, "drives low only");
        // Pin level reaches the register through two flip-flops
        repeat (2) @(negedge MCLK);
        bus(1'b0, tai_pkg::OFS_CONFIG, 8'h00);
        chk(q & 32'h00000080, 32'h00000000, "line low");
        conv(1'b0, 8'h53);
        chk(32'(PIN_OE), 32'h1, "second band");
        conv(1'b0, 8'h52);
        chk(32'(PIN_OE), 32'h0, "second released");
        repeat (2) @(negedge MCLK);
        bus(1'b0, tai_pkg::OFS_CONFIG, 8'h00);
        chk(q & 32'h00000080, 32'h00000080, "line high");
        conv(1'b1, 8'h56);
        chk(32'(PIN_OE), 32'h1, "remote second");
        conv(1'b1, 8'h20);
        bus(1'b1, tai_pkg::OFS_CONFIG, 8'h00);
        $display("second trip test done");
    endtask : t_second

    initial begin
        repeat (16) @(posedge MCLK);
        SRST <= 1'b0;
        t_reset();
        t_trip();
        t_offset();
        t_alarm();
        t_mask();
        t_second();
        test_done();
    end
endmodule : tai_alarm_top_test
